// ### logic/led_pkg.sv
/*
  Shared constants and carrier types for the link error detect flag block:
  register offsets, flag positions, reset values, timing counts and the
  structs that carry received control symbols and delineation events.
  Assumes a 10 MHz clock and a 32-bit APB register bus.
*/
// Functional notes
// - Set bit 26 when a link response names a non-outstanding ackID; no capture.
// - Recovery sends a link request; partner answers with its expected ackID.
// - A response naming an accepted packet halts transfers until ackIDs realign.
// - Set bit 27 on a control symbol unexpected in the current link state, other than an ack in REC_IDLE (bit 30).
// - Set bit 29 on misaligned start-control/delimiter or undefined code-group.
// - Set bit 30 on any acknowledge control symbol that was not expected; acks outside REC_IDLE set bit 27 instead.
// - Set bit 31 when acknowledge or link response times out; no capture.

package led_pkg;

  // ==========================================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_ERR_DETECT = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_LINK_STATUS = 8'h08;
  localparam logic [7:0] OFS_TIMEOUT = 8'h0C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;

  // ==========================================================================
  // Flag positions and reset values
  localparam int BIT_LR_ACKID_MISMATCH = 26;
  localparam int BIT_UNEXP_CS = 27;
  localparam int BIT_RESERVED = 28;
  localparam int BIT_DELINEATION = 29;
  localparam int BIT_UNEXP_ACK = 30;
  localparam int BIT_ACK_RESP_TIMEOUT = 31;
  localparam logic [31:0] FLAG_MASK = 32'hEC00_0000;
  localparam logic [31:0] RESET_FLAGS = 32'h0000_0000;
  localparam logic [31:0] RESET_MASK = 32'h0000_0000;

  // Control register bits (write-one pulses)
  localparam int CTRL_START_RECOVERY = 0;
  localparam int CTRL_REALIGN = 1;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_W = 16;
  localparam logic [15:0] RESET_TIMEOUT_TICKS = 16'h0064;

  // ==========================================================================
  // Link-side carriers
  localparam int ACKID_W = 5;

  typedef enum logic [2:0] {
    CS_ACCEPTED = 3'b000,
    CS_RETRY = 3'b001,
    CS_NOT_ACCEPTED = 3'b010,
    CS_LINK_RESPONSE = 3'b011,
    CS_STATUS = 3'b100,
    CS_RESERVED_5 = 3'b101,
    CS_RESERVED_6 = 3'b110,
    CS_RESERVED_7 = 3'b111
  } led_cs_kind_t;

  typedef struct packed {
    logic valid;
    led_cs_kind_t kind;
    logic [ACKID_W-1:0] ackid;
  } led_rx_cs_t;

  typedef struct packed {
    logic sc_misaligned;
    logic pd_misaligned;
    logic undefined_code_group;
  } led_delin_t;

  typedef enum logic [1:0] {
    REC_IDLE = 2'b00,
    REC_SEND = 2'b01,
    REC_WAIT = 2'b10,
    REC_HALT = 2'b11
  } led_rec_state_t;

endpackage

// ### logic/led_timeout_timer.sv
/*
  Timeout timer: a prescaler makes a one-cycle tick enable, and a tick
  counter reports a one-cycle expiry when it reaches the programmed limit.
  Assumes run_i and restart_i are synchronous; a limit of zero disables it.
*/
`timescale 1ns/1ps
`default_nettype none

module led_timeout_timer #(
  parameter int TICK_CYCLES = led_pkg::TICK_CYCLES,
  parameter int LIMIT_W = led_pkg::TIMEOUT_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [LIMIT_W-1:0] limit_i,
  output logic expired_o
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535 || LIMIT_W < 1) begin : g_bad_param
    $error("led_timeout_timer: unsupported parameter values");
  end

  logic [15:0] presc;
  logic [LIMIT_W-1:0] ticks;
  logic tick_en;

  // ==========================================================================
  // Prescaler
  assign tick_en = (presc == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      presc <= 16'h0000;
    end else if (!run_i || restart_i || tick_en) begin
      presc <= 16'h0000;
    end else begin
      presc <= presc + 16'h0001;
    end
  end

  // ==========================================================================
  // Tick counter; expiry clears it so a held run_i re-arms the interval
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ticks <= '0;
      expired_o <= 1'b0;
    end else if (!run_i || restart_i || limit_i == '0) begin
      ticks <= '0;
      expired_o <= 1'b0;
    end else if (tick_en && ticks + 1'b1 >= limit_i) begin
      ticks <= '0;
      expired_o <= 1'b1;
    end else begin
      expired_o <= 1'b0;
      if (tick_en) begin
        ticks <= ticks + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### logic/led_error_detect.sv
/*
  Per-port link error detect flags with the link-level tracking that
  raises them: outstanding ackID window, recovery by link request,
  acknowledge and response timeout, APB register slave and interrupt.
  Assumes link-side inputs are synchronous pulses from the port's
  receiver and transmitter; the transmitter obeys tx_halt_o.
*/
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module led_error_detect #(
  parameter logic [15:0] TIMEOUT_TICKS_DEFAULT = led_pkg::RESET_TIMEOUT_TICKS,
  parameter int TICK_CYCLES = led_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [led_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire led_pkg::led_rx_cs_t rx_cs_i,
  input wire led_pkg::led_delin_t delin_i,
  input wire logic recovery_req_i,
  input wire logic tx_packet_sent_i,
  output logic link_request_o,
  output logic tx_halt_o,
  output logic irq_o
);

  if (TICK_CYCLES < 1 || TIMEOUT_TICKS_DEFAULT == 16'h0000) begin : g_bad_param
    $error("led_error_detect: unsupported parameter values");
  end

  localparam int AW = led_pkg::ACKID_W;

  // ==========================================================================
  // Helpers
  function automatic logic [AW-1:0] ackid_dist(input logic [AW-1:0] a,
                                                input logic [AW-1:0] base);
    ackid_dist = AW'(a - base);
  endfunction

  function automatic logic reg_mapped(input logic [led_pkg::ADDR_W-1:0] a);
    reg_mapped = (a == led_pkg::OFS_ERR_DETECT) || (a == led_pkg::OFS_CONTROL) ||
                 (a == led_pkg::OFS_LINK_STATUS) || (a == led_pkg::OFS_TIMEOUT) ||
                 (a == led_pkg::OFS_INT_STATUS) || (a == led_pkg::OFS_INT_MASK);
  endfunction

  // ==========================================================================
  // State
  logic [31:0] err_detect;
  logic [31:0] int_status;
  logic [31:0] int_mask;
  logic [15:0] timeout_ticks;
  led_pkg::led_rec_state_t rec_state;
  led_pkg::led_rec_state_t next_rec_state;
  logic [AW-1:0] ack_expected;
  logic [AW-1:0] next_tx;
  logic [AW-1:0] partner_ackid;
  logic [AW-1:0] outstanding;
  logic [31:0] events;
  logic [31:0] next_err_detect;
  logic [31:0] next_int_status;
  logic [31:0] read_value;
  logic setup_phase;
  logic wr_done;
  logic rd_done;
  logic start_recovery;
  logic realign;
  logic is_ack;
  logic ack_good;
  logic ack_advance;
  logic ack_rewind;
  logic resp_accept;
  logic resp_mismatch;
  logic send_allowed;
  logic timer_run;
  logic timer_restart;
  logic timer_expired;

  // ==========================================================================
  // APB decode
  assign setup_phase = psel_i & ~penable_i;
  assign wr_done = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  assign rd_done = psel_i & penable_i & pready_o & ~pwrite_i & ~pslverr_o;
  assign start_recovery = wr_done && paddr_i == led_pkg::OFS_CONTROL &&
                          pwdata_i[led_pkg::CTRL_START_RECOVERY];
  assign realign = wr_done && paddr_i == led_pkg::OFS_CONTROL &&
                   pwdata_i[led_pkg::CTRL_REALIGN];

  always_comb begin
    read_value = 32'h0000_0000;
    unique case (paddr_i)
      led_pkg::OFS_ERR_DETECT: read_value = err_detect & led_pkg::FLAG_MASK;
      led_pkg::OFS_LINK_STATUS: read_value = {14'h0000, tx_halt_o, rec_state,
                                              partner_ackid, ack_expected, next_tx};
      led_pkg::OFS_TIMEOUT: read_value = {16'h0000, timeout_ticks};
      led_pkg::OFS_INT_STATUS: read_value = int_status;
      led_pkg::OFS_INT_MASK: read_value = int_mask;
      default: read_value = 32'h0000_0000;
    endcase
  end

  // Read data is latched in the setup cycle so the access edge sees stable data
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup_phase;
      if (setup_phase) begin
        pslverr_o <= ~reg_mapped(paddr_i);
        prdata_o <= reg_mapped(paddr_i) ? read_value : 32'h0000_0000;
      end else if (pready_o) begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Link tracking decisions
  assign outstanding = ackid_dist(next_tx, ack_expected);
  assign is_ack = rx_cs_i.valid && (rx_cs_i.kind == led_pkg::CS_ACCEPTED ||
                                    rx_cs_i.kind == led_pkg::CS_RETRY ||
                                    rx_cs_i.kind == led_pkg::CS_NOT_ACCEPTED);
  // An acknowledge is only expected for the oldest outstanding packet
  assign ack_good = is_ack && rec_state == led_pkg::REC_IDLE &&
                    outstanding != '0 && rx_cs_i.ackid == ack_expected;
  assign ack_advance = ack_good && rx_cs_i.kind == led_pkg::CS_ACCEPTED;
  assign ack_rewind = ack_good && rx_cs_i.kind == led_pkg::CS_RETRY;

  // Partner may name any outstanding ackID or the next unsent one
  assign resp_accept = rec_state == led_pkg::REC_WAIT && rx_cs_i.valid &&
                       rx_cs_i.kind == led_pkg::CS_LINK_RESPONSE &&
                       ackid_dist(rx_cs_i.ackid, ack_expected) <= outstanding;
  assign resp_mismatch = rec_state == led_pkg::REC_WAIT && rx_cs_i.valid &&
                         rx_cs_i.kind == led_pkg::CS_LINK_RESPONSE &&
                         ackid_dist(rx_cs_i.ackid, ack_expected) > outstanding;

  // One slot of the ackID space stays unused so full and empty differ
  assign send_allowed = rec_state == led_pkg::REC_IDLE &&
                        outstanding != {AW{1'b1}};

  always_comb begin
    events = 32'h0000_0000;
    events[led_pkg::BIT_LR_ACKID_MISMATCH] = resp_mismatch;
    // Link responses outside REC_WAIT, acks during recovery, reserved kinds
    events[led_pkg::BIT_UNEXP_CS] = rx_cs_i.valid && (
        (rx_cs_i.kind == led_pkg::CS_LINK_RESPONSE &&
         rec_state != led_pkg::REC_WAIT) ||
        (is_ack && rec_state != led_pkg::REC_IDLE) ||
        rx_cs_i.kind == led_pkg::CS_RESERVED_5 ||
        rx_cs_i.kind == led_pkg::CS_RESERVED_6 ||
        rx_cs_i.kind == led_pkg::CS_RESERVED_7);
    events[led_pkg::BIT_DELINEATION] = delin_i.sc_misaligned |
                                       delin_i.pd_misaligned |
                                       delin_i.undefined_code_group;
    events[led_pkg::BIT_UNEXP_ACK] = is_ack && rec_state == led_pkg::REC_IDLE &&
                                     !ack_good;
    events[led_pkg::BIT_ACK_RESP_TIMEOUT] = timer_expired;
  end

  // ==========================================================================
  // Recovery state machine
  always_comb begin
    next_rec_state = rec_state;
    unique case (rec_state)
      led_pkg::REC_IDLE: begin
        if (recovery_req_i || start_recovery || timer_expired ||
            (ack_good && rx_cs_i.kind == led_pkg::CS_NOT_ACCEPTED)) begin
          next_rec_state = led_pkg::REC_SEND;
        end
      end
      led_pkg::REC_SEND: begin
        next_rec_state = led_pkg::REC_WAIT;
      end
      led_pkg::REC_WAIT: begin
        if (resp_accept) begin
          next_rec_state = led_pkg::REC_IDLE;
        end else if (resp_mismatch) begin
          next_rec_state = led_pkg::REC_HALT;
        end else if (timer_expired) begin
          next_rec_state = led_pkg::REC_SEND;
        end
      end
      led_pkg::REC_HALT: begin
        if (realign) begin
          next_rec_state = led_pkg::REC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rec_state <= led_pkg::REC_IDLE;
    end else begin
      rec_state <= next_rec_state;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      link_request_o <= 1'b0;
    end else begin
      link_request_o <= next_rec_state == led_pkg::REC_SEND;
    end
  end

  // Transfers stop through recovery and stay stopped while misaligned
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_halt_o <= 1'b0;
    end else begin
      tx_halt_o <= next_rec_state != led_pkg::REC_IDLE ||
                   ackid_dist(next_tx, ack_expected) >= {AW{1'b1}} - 1'b1;
    end
  end

  // ==========================================================================
  // AckID window
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_expected <= '0;
    end else if (rec_state == led_pkg::REC_HALT && realign) begin
      ack_expected <= partner_ackid;
    end else if (resp_accept) begin
      ack_expected <= rx_cs_i.ackid;
    end else if (ack_advance) begin
      ack_expected <= AW'(ack_expected + 1'b1);
    end
  end

  // A retry or an accepted response rewinds so the transmitter resends
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      next_tx <= '0;
    end else if (rec_state == led_pkg::REC_HALT && realign) begin
      next_tx <= partner_ackid;
    end else if (resp_accept) begin
      next_tx <= rx_cs_i.ackid;
    end else if (ack_rewind) begin
      next_tx <= ack_expected;
    end else if (tx_packet_sent_i && send_allowed) begin
      next_tx <= AW'(next_tx + 1'b1);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      partner_ackid <= '0;
    end else if (rec_state == led_pkg::REC_WAIT && rx_cs_i.valid &&
                 rx_cs_i.kind == led_pkg::CS_LINK_RESPONSE) begin
      partner_ackid <= rx_cs_i.ackid;
    end
  end

  // ==========================================================================
  // Acknowledge / response timeout
  assign timer_run = (rec_state == led_pkg::REC_IDLE && outstanding != '0) ||
                     rec_state == led_pkg::REC_WAIT;
  assign timer_restart = ack_advance || ack_rewind || link_request_o ||
                         (tx_packet_sent_i && outstanding == '0);

  led_timeout_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .LIMIT_W(led_pkg::TIMEOUT_W)
  ) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .run_i(timer_run),
    .restart_i(timer_restart),
    .limit_i(timeout_ticks),
    .expired_o(timer_expired)
  );

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      timeout_ticks <= TIMEOUT_TICKS_DEFAULT;
    end else if (wr_done && paddr_i == led_pkg::OFS_TIMEOUT) begin
      timeout_ticks <= pwdata_i[15:0];
    end
  end

  // ==========================================================================
  // Detect flags: write zero clears, a same-cycle event wins
  always_comb begin
    next_err_detect = err_detect;
    if (wr_done && paddr_i == led_pkg::OFS_ERR_DETECT) begin
      next_err_detect = err_detect & pwdata_i;
    end
    next_err_detect = (next_err_detect | events) & led_pkg::FLAG_MASK;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      err_detect <= led_pkg::RESET_FLAGS;
    end else begin
      err_detect <= next_err_detect;
    end
  end

  // ==========================================================================
  // Interrupt status: read clears only the bits that were returned
  always_comb begin
    next_int_status = int_status;
    if (rd_done && paddr_i == led_pkg::OFS_INT_STATUS) begin
      next_int_status = int_status & ~prdata_o;
    end
    next_int_status = (next_int_status | events) & led_pkg::FLAG_MASK;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      int_status <= led_pkg::RESET_FLAGS;
    end else begin
      int_status <= next_int_status;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      int_mask <= led_pkg::RESET_MASK;
    end else if (wr_done && paddr_i == led_pkg::OFS_INT_MASK) begin
      int_mask <= pwdata_i & led_pkg::FLAG_MASK;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_int_status & int_mask);
    end
  end

endmodule

`default_nettype wire

// ### verif/led_link_partner.sv
/*
  Link partner model: answers each link request with a link response after
  a delay the bench selects, naming the ackID the bench selects.
  Assumes link_request_i is a one-cycle pulse on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module led_link_partner (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic link_request_i,
  input wire logic [4:0] resp_ackid_i,
  input wire logic [7:0] resp_delay_i,
  output var led_pkg::led_rx_cs_t rx_cs_o
);
  // ========================================
  // Response timing
  logic pending;
  logic [7:0] wait_cnt;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pending <= 1'b0;
      wait_cnt <= 8'h00;
      rx_cs_o <= '0;
    end else begin
      // Idle fields keep toggling so a stale symbol is never reused
      rx_cs_o.valid <= 1'b0;
      rx_cs_o.kind <= led_pkg::led_cs_kind_t'(~rx_cs_o.kind);
      rx_cs_o.ackid <= ~rx_cs_o.ackid;
      if (link_request_i) begin
        pending <= 1'b1;
        wait_cnt <= resp_delay_i;
      end else if (pending && wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end else if (pending) begin
        pending <= 1'b0;
        rx_cs_o.valid <= 1'b1;
        rx_cs_o.kind <= led_pkg::CS_LINK_RESPONSE;
        rx_cs_o.ackid <= resp_ackid_i;
      end
    end
  end
endmodule

`default_nettype wire

// ### verif/led_error_detect_checker.sv
/*
  Checker for the link error detect flags, watching only top-level ports.
  Assumes it is bound into led_error_detect; one clock, async reset.
*/
`timescale 1ns/1ps
`default_nettype none

module led_error_detect_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire led_pkg::led_rx_cs_t rx_cs_i,
  input wire led_pkg::led_delin_t delin_i,
  input wire logic recovery_req_i,
  input wire logic tx_packet_sent_i,
  input wire logic link_request_o,
  input wire logic tx_halt_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ========================================
  // Decoded bus events
  wire logic acc = psel_i & penable_i & pready_o;
  wire logic at_flags = paddr_i == led_pkg::OFS_ERR_DETECT;
  wire logic rd_flags = acc & ~pwrite_i & at_flags;
  wire logic wr_flags = acc & pwrite_i & ~pslverr_o & at_flags;
  wire logic wr_ctrl = acc & pwrite_i & (paddr_i == led_pkg::OFS_CONTROL) & pwdata_i[0];
  wire logic wr_mask0 = acc & pwrite_i & (paddr_i == led_pkg::OFS_INT_MASK) & ~|pwdata_i;
  wire logic mapped = paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  wire logic resv_cs = rx_cs_i.valid & rx_cs_i.kind[2] & (rx_cs_i.kind[1] | rx_cs_i.kind[0]);

  // ========================================
  // Shadow flags for causes visible at the ports; set wins over clear
  logic seen_delin;
  logic seen_resv;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seen_delin <= 1'b0;
    end else if (|delin_i) begin
      seen_delin <= 1'b1;
    end else if (wr_flags && !pwdata_i[29]) begin
      seen_delin <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seen_resv <= 1'b0;
    end else if (resv_cs) begin
      seen_resv <= 1'b1;
    end else if (wr_flags && !pwdata_i[27]) begin
      seen_resv <= 1'b0;
    end
  end

  sequence s_setup;
    psel_i && !penable_i;
  endsequence

  sequence s_rec_trigger;
    (recovery_req_i || wr_ctrl) && !tx_halt_o;
  endsequence

  // ========================================
  // Properties
  chk_pready_next: assert property (s_setup |=> pready_o)
    else $error("access cycle without ready");
  chk_pready_once: assert property (pready_o |=> !pready_o)
    else $error("ready held past one cycle");
  chk_unmapped_err: assert property (acc |-> pslverr_o == !mapped)
    else $error("slave error does not match address map");
  chk_resv_zero: assert property (rd_flags |-> (prdata_o & ~led_pkg::FLAG_MASK) == 32'h0)
    else $error("reserved flag bits read nonzero");
  chk_delin_flag: assert property (rd_flags |-> prdata_o[29] == $past(seen_delin))
    else $error("delineation flag wrong");
  chk_resv_cs_flag: assert property (rd_flags && $past(seen_resv) |-> prdata_o[27])
    else $error("unexpected symbol flag missing");
  chk_req_pulse: assert property ($rose(link_request_o) |=> !link_request_o)
    else $error("link request longer than one cycle");
  chk_req_halted: assert property (link_request_o |-> tx_halt_o)
    else $error("link request while transmit open");
  chk_rec_start: assert property (s_rec_trigger |-> ##[1:2] link_request_o)
    else $error("recovery sent no link request");
  chk_irq_masked: assert property (wr_mask0 |-> ##[1:2] !irq_o)
    else $error("interrupt high with mask cleared");
endmodule

`default_nettype wire

// ### verif/led_error_detect_tb_top.sv
/*
  Self-checking bench for the link error detect flags: APB master tasks,
  then reset, a row table of link events, sticky, interrupt and recovery.
  Assumes the design package and the link partner model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module led_error_detect_tb_top;
  typedef struct packed {logic [8:0] cs; logic [2:0] dl; logic [31:0] exp;} led_row_t;
  logic clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic recovery_req_i, tx_packet_sent_i, link_request_o, tx_halt_o, irq_o, err;
  logic [7:0] paddr_i, resp_delay;
  logic [31:0] pwdata_i, prdata_o, rd;
  led_pkg::led_rx_cs_t tb_cs, p_cs, cs_mux;
  led_pkg::led_delin_t delin_i;
  led_row_t rows [9];
  int failures, checks;

  assign cs_mux = p_cs.valid ? p_cs : tb_cs;

  // Prescaler of one cycle keeps timeout runs short
  led_error_detect #(.TICK_CYCLES(1)) dut (.clk_i, .reset_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_cs_i(cs_mux),
    .delin_i, .recovery_req_i, .tx_packet_sent_i, .link_request_o, .tx_halt_o, .irq_o);

  led_link_partner partner (.clk_i, .reset_i, .link_request_i(link_request_o),
    .resp_ackid_i(5'h00), .resp_delay_i(resp_delay), .rx_cs_o(p_cs));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ========================================
  // Tasks
  task automatic give_verdict();
    $display("Counts: checks %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    while (n < 20) begin
      @(posedge clk_i);
      n++;
      if (pready_o === 1'b1) break;
    end
    if (pready_o !== 1'b1) begin
      failures++;
      $display("ERROR t=%0t bus wait ran out", $time);
      give_verdict();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask

  task automatic ev(input logic [8:0] cs, input logic [2:0] dl);
    @(posedge clk_i);
    tb_cs <= cs;
    delin_i <= dl;
    @(posedge clk_i);
    tb_cs <= '0;
    delin_i <= '0;
  endtask

  task automatic pkt();
    @(posedge clk_i);
    tx_packet_sent_i <= 1'b1;
    @(posedge clk_i);
    tx_packet_sent_i <= 1'b0;
  endtask

  task automatic wait_req();
    int n;
    n = 0;
    while (link_request_o !== 1'b1 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    if (link_request_o !== 1'b1) begin
      failures++;
      $display("ERROR t=%0t no link request", $time);
      give_verdict();
    end
  endtask

  // ========================================
  // Main sequence
  initial begin
    reset_i = 1'b1;
    {psel_i, penable_i, pwrite_i, recovery_req_i, tx_packet_sent_i} = 5'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    tb_cs = '0;
    delin_i = '0;
    resp_delay = 8'h05;
    failures = 0;
    checks = 0;
    rows = '{{9'h000, 3'h4, 32'h2000_0000}, {9'h000, 3'h2, 32'h2000_0000},
      {9'h000, 3'h1, 32'h2000_0000}, {9'h1A0, 3'h0, 32'h0800_0000},
      {9'h1C0, 3'h0, 32'h0800_0000}, {9'h1E0, 3'h0, 32'h0800_0000},
      {9'h160, 3'h0, 32'h0800_0000}, {9'h100, 3'h0, 32'h4000_0000},
      {9'h180, 3'h0, 32'h0000_0000}};
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    rdchk(led_pkg::OFS_ERR_DETECT, 32'h0000_0000);
    rdchk(led_pkg::OFS_INT_MASK, 32'h0000_0000);
    rdchk(led_pkg::OFS_TIMEOUT, 32'h0000_0064);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    $display("Test reset done");
    foreach (rows[i]) begin
      apb(1'b1, led_pkg::OFS_ERR_DETECT, 32'h0000_0000);
      ev(rows[i].cs, rows[i].dl);
      rdchk(led_pkg::OFS_ERR_DETECT, rows[i].exp);
    end
    $display("Test event table done");
    ev(9'h000, 3'h4);
    apb(1'b1, led_pkg::OFS_ERR_DETECT, 32'hFFFF_FFFF);
    rdchk(led_pkg::OFS_ERR_DETECT, 32'h2000_0000);
    apb(1'b1, led_pkg::OFS_ERR_DETECT, 32'h0000_0000);
    rdchk(led_pkg::OFS_ERR_DETECT, 32'h0000_0000);
    $display("Test sticky clear done");
    rdchk(led_pkg::OFS_INT_STATUS, 32'h6800_0000);
    apb(1'b1, led_pkg::OFS_INT_MASK, 32'h4000_0000);
    ev(9'h100, 3'h0);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0000_0001);
    rdchk(led_pkg::OFS_INT_STATUS, 32'h4000_0000);
    ev(9'h000, 3'h1);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0000_0000);
    rdchk(led_pkg::OFS_INT_STATUS, 32'h2000_0000);
    apb(1'b1, led_pkg::OFS_INT_MASK, 32'h0000_0000);
    apb(1'b1, led_pkg::OFS_ERR_DETECT, 32'h0000_0000);
    $display("Test interrupt done");
    @(posedge clk_i);
    recovery_req_i <= 1'b1;
    @(posedge clk_i);
    recovery_req_i <= 1'b0;
    wait_req();
    check({31'h0, tx_halt_o}, 32'h0000_0001);
    repeat (12) @(posedge clk_i);
    check({31'h0, tx_halt_o}, 32'h0000_0000);
    rdchk(led_pkg::OFS_ERR_DETECT, 32'h0000_0000);
    $display("Test slow recovery done");
    resp_delay <= 8'h01;
    apb(1'b1, led_pkg::OFS_TIMEOUT, 32'h0000_0005);
    pkt();
    ev(9'h100, 3'h0);
    pkt();
    wait_req();
    repeat (10) @(posedge clk_i);
    check({31'h0, tx_halt_o}, 32'h0000_0001);
    rdchk(led_pkg::OFS_ERR_DETECT, 32'h8400_0000);
    apb(1'b0, led_pkg::OFS_LINK_STATUS, 32'h0000_0000);
    check({30'h0, rd[16:15]}, 32'h0000_0003);
    apb(1'b1, led_pkg::OFS_CONTROL, 32'h0000_0002);
    repeat (3) @(posedge clk_i);
    check({31'h0, tx_halt_o}, 32'h0000_0000);
    $display("Test timeout mismatch done");
    give_verdict();
  end
endmodule

bind led_error_detect led_error_detect_checker chk (.clk_i, .reset_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_cs_i, .delin_i,
  .recovery_req_i, .tx_packet_sent_i, .link_request_o, .tx_halt_o, .irq_o);

`default_nettype wire
